//--- logic/ccr_edge.sv
`timescale 1ns/10ps
// Registered rise/fall detector for a synchronous level
module ccr_edge (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, active low
  input wire logic level_in, // Level to watch
  output logic level_q, // Registered copy
  output logic rise, // One-cycle pulse on rise
  output logic fall // One-cycle pulse on fall
);
  typedef struct packed {
    logic q;
    logic rise;
    logic fall;
  } ccr_edge_t;
  ccr_edge_t s_reg;
  ccr_edge_t s_next;

  // Compare new level against held copy
  always_comb begin
    s_next = s_reg;
    s_next.q = level_in;
    s_next.rise = level_in & ~s_reg.q;
    s_next.fall = ~level_in & s_reg.q;
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign level_q = s_reg.q;
  assign rise = s_reg.rise;
  assign fall = s_reg.fall;
endmodule // ccr_edge

//--- logic/ccr_pkg.sv
package ccr_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [11:0] CONV_CTRL_OFF = 12'h000;
  localparam logic [11:0] LDO_BOOST_OFF = 12'h004;
  localparam logic [11:0] IRQ_STATUS_OFF = 12'h008;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h00c;
  localparam logic [11:0] SUPPLY_STAT_OFF = 12'h010;

  // ----------------------------------------------------------------
  // Converter control fields
  // ----------------------------------------------------------------
  localparam int SHUTDOWN_BIT = 7;
  localparam int VIRQ_BIT = 6;
  localparam int VGOOD_BIT = 5;
  localparam int ZERO_BIT = 4;
  localparam int OVF_ADJ_BIT = 3;
  localparam int STEP_INH_BIT = 2;
  localparam int VSEL_LSB = 0;

  // Voltage select codes
  localparam logic [1:0] VSEL_0V0 = 2'h0;
  localparam logic [1:0] VSEL_2V2 = 2'h1;
  localparam logic [1:0] VSEL_3V2 = 2'h2;
  localparam logic [1:0] VSEL_5V2 = 2'h3;

  // Regulator boost field: bits 7..4 are regulators 5..2
  localparam int BOOST_LSB = 4;

  // Reset values
  localparam logic [7:0] CONV_CTRL_RST = 8'h00;
  localparam logic [7:0] LDO_BOOST_RST = 8'h0f;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // Interrupt status bits
  localparam int EV_GOOD_RISE = 0;
  localparam int EV_GOOD_FALL = 1;
endpackage

//--- logic/ccr_regs.sv
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/10ps
// What this block does
// - Shutdown bit stops converter, deactivates cards
// - Voltage flag sets when output-good rises
// - Reading control register clears voltage flag
// - Adjust bit raises overflow threshold twenty percent
// - Step-up inhibit bit disables step-up
// - Select codes give 0, 2.2, 3.2, 5.2V
// - Control register resets to all zeros
// - Boost bits raise regulator 5..2 current
// - Regulator register resets to 0x0f
module ccr_regs (
  input wire logic pclk, // 20 MHz system clock
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic converter_output_good, // Analog: converter at target
  output logic converter_enable, // Converter on
  output logic card_deactivate_req, // Pulse: run deactivation sequence
  output logic overflow_sensitivity_adjust, // Raise overflow threshold
  output logic step_up_inhibit, // Step-up disabled
  output logic [1:0] converter_voltage_select, // Target level code
  output logic [3:0] regulator_current_boost, // Regulators 5..2 boost
  output logic irq // Level interrupt
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic shutdown;
    logic virq_flag;
    logic ovf_adj;
    logic step_inh;
    logic [1:0] vsel;
    logic [3:0] boost;
    logic [3:0] ldo_low;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic conv_en;
    logic deact;
    logic irq;
  } ccr_regs_t;
  ccr_regs_t s_reg;
  ccr_regs_t s_next;

  logic good_q;
  logic good_rise;
  logic good_fall;

  // Output-good tracked through a registered edge detector
  ccr_edge u_good_edge (
    .pclk(pclk),
    .presetn(presetn),
    .level_in(converter_output_good),
    .level_q(good_q),
    .rise(good_rise),
    .fall(good_fall)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic access;
  logic wr;
  logic rd;
  logic mapped;
  assign access = psel & penable & ~s_reg.ready;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign mapped = (paddr == ccr_pkg::CONV_CTRL_OFF) || (paddr == ccr_pkg::LDO_BOOST_OFF) ||
                  (paddr == ccr_pkg::IRQ_STATUS_OFF) || (paddr == ccr_pkg::IRQ_MASK_OFF) ||
                  (paddr == ccr_pkg::SUPPLY_STAT_OFF);

  // Live view of the control byte; good bit is never stored
  logic [7:0] ctrl_view;
  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[ccr_pkg::SHUTDOWN_BIT] = s_reg.shutdown;
    ctrl_view[ccr_pkg::VIRQ_BIT] = s_reg.virq_flag;
    ctrl_view[ccr_pkg::VGOOD_BIT] = good_q;
    ctrl_view[ccr_pkg::ZERO_BIT] = 1'b0;
    ctrl_view[ccr_pkg::OVF_ADJ_BIT] = s_reg.ovf_adj;
    ctrl_view[ccr_pkg::STEP_INH_BIT] = s_reg.step_inh;
    ctrl_view[ccr_pkg::VSEL_LSB +: 2] = s_reg.vsel;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.ready = access;
    s_next.err = access & ~mapped;
    s_next.deact = 1'b0;
    if (!access) begin
      s_next.rdata = 32'h0000_0000;
    end
    // Writes take effect in the one-wait access cycle
    if (wr) begin
      unique case (paddr)
        ccr_pkg::CONV_CTRL_OFF: begin
          s_next.shutdown = pwdata[ccr_pkg::SHUTDOWN_BIT];
          s_next.ovf_adj = pwdata[ccr_pkg::OVF_ADJ_BIT];
          s_next.step_inh = pwdata[ccr_pkg::STEP_INH_BIT];
          // Select change alone never triggers deactivation
          s_next.vsel = pwdata[ccr_pkg::VSEL_LSB +: 2];
          if (pwdata[ccr_pkg::SHUTDOWN_BIT] && !s_reg.shutdown) begin
            s_next.deact = 1'b1;
          end
        end
        ccr_pkg::LDO_BOOST_OFF: begin
          s_next.boost = pwdata[ccr_pkg::BOOST_LSB +: 4];
          // Low nibble kept as written; software must keep it at ones
          s_next.ldo_low = pwdata[3:0];
        end
        ccr_pkg::IRQ_STATUS_OFF: begin
          s_next.irq_status = s_reg.irq_status & ~pwdata[1:0];
        end
        ccr_pkg::IRQ_MASK_OFF: begin
          s_next.irq_mask = pwdata[1:0];
        end
        default: begin
        end
      endcase
    end
    // Reads capture data and apply read side effects
    if (rd) begin
      unique case (paddr)
        ccr_pkg::CONV_CTRL_OFF: begin
          s_next.rdata = {24'h000000, ctrl_view};
          s_next.virq_flag = 1'b0;
        end
        ccr_pkg::LDO_BOOST_OFF: s_next.rdata = {24'h000000, s_reg.boost, s_reg.ldo_low};
        ccr_pkg::IRQ_STATUS_OFF: s_next.rdata = {30'h00000000, s_reg.irq_status};
        ccr_pkg::IRQ_MASK_OFF: s_next.rdata = {30'h00000000, s_reg.irq_mask};
        ccr_pkg::SUPPLY_STAT_OFF: s_next.rdata = {31'h00000000, good_q};
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
    // Hardware sets win over software clears
    if (good_rise) begin
      s_next.virq_flag = 1'b1;
      s_next.irq_status[ccr_pkg::EV_GOOD_RISE] = 1'b1;
    end
    if (good_fall) begin
      s_next.irq_status[ccr_pkg::EV_GOOD_FALL] = 1'b1;
    end
    s_next.conv_en = ~s_next.shutdown;
    s_next.irq = |(s_next.irq_status & s_next.irq_mask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.shutdown <= ccr_pkg::CONV_CTRL_RST[ccr_pkg::SHUTDOWN_BIT];
      s_reg.virq_flag <= ccr_pkg::CONV_CTRL_RST[ccr_pkg::VIRQ_BIT];
      s_reg.ovf_adj <= ccr_pkg::CONV_CTRL_RST[ccr_pkg::OVF_ADJ_BIT];
      s_reg.step_inh <= ccr_pkg::CONV_CTRL_RST[ccr_pkg::STEP_INH_BIT];
      s_reg.vsel <= ccr_pkg::CONV_CTRL_RST[1:0];
      s_reg.boost <= ccr_pkg::LDO_BOOST_RST[7:4];
      s_reg.ldo_low <= ccr_pkg::LDO_BOOST_RST[3:0];
      s_reg.irq_mask <= ccr_pkg::IRQ_MASK_RST;
      s_reg.conv_en <= ~ccr_pkg::CONV_CTRL_RST[ccr_pkg::SHUTDOWN_BIT];
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------
  assign prdata = s_reg.rdata;
  assign pready = s_reg.ready;
  assign pslverr = s_reg.err;
  assign converter_enable = s_reg.conv_en;
  assign card_deactivate_req = s_reg.deact;
  assign overflow_sensitivity_adjust = s_reg.ovf_adj;
  assign step_up_inhibit = s_reg.step_inh;
  assign converter_voltage_select = s_reg.vsel;
  assign regulator_current_boost = s_reg.boost;
  assign irq = s_reg.irq;
endmodule // ccr_regs

//--- verif/ccr_regs_asserts.sv
`timescale 1ns/10ps
// ----
// Control and boost register effects and the one-wait answer at the ports
// ----
module ccr_regs_asserts (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic converter_enable, // Converter on
  input wire logic card_deactivate_req, // Deactivate pulse
  input wire logic overflow_sensitivity_adjust, // Adjust
  input wire logic step_up_inhibit, // Inhibit
  input wire logic [1:0] converter_voltage_select, // Level code
  input wire logic [3:0] regulator_current_boost // Boost
);
  logic done;
  logic wr_ctrl;
  logic wr_ldo;
  // Writes land at the edge that raises pready, one edge before the completing edge
  assign done = psel && penable && pready;
  assign wr_ctrl = done && pwrite && paddr == ccr_pkg::CONV_CTRL_OFF;
  assign wr_ldo = done && pwrite && paddr == ccr_pkg::LDO_BOOST_OFF;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  shut_ctrl_a: assert property (wr_ctrl |=> converter_enable == !$past(pwdata[7]))
    else $error("enable does not follow shutdown");
  deact_pulse_a: assert property (card_deactivate_req |-> !converter_enable ##1 !card_deactivate_req)
    else $error("bad deactivation pulse");
  ovf_adjust_a: assert property (wr_ctrl |=> overflow_sensitivity_adjust == $past(pwdata[3]))
    else $error("adjust bit not applied");
  step_inhibit_a: assert property (wr_ctrl |=> step_up_inhibit == $past(pwdata[2]))
    else $error("inhibit bit not applied");
  volt_select_a: assert property (wr_ctrl |=> converter_voltage_select == $past(pwdata[1:0]))
    else $error("voltage code not applied");
  vsel_no_deact_a: assert property (psel && penable && !pready && pwrite &&
    paddr == ccr_pkg::CONV_CTRL_OFF && !pwdata[7] |=> !card_deactivate_req)
    else $error("deactivation without shutdown");
  boost_write_a: assert property (wr_ldo |=> regulator_current_boost == $past(pwdata[7:4]))
    else $error("boost bits not applied");
  ctrl_zero_bits_a: assert property (done && !pwrite && paddr == 12'h000 |-> prdata[31:8] == 24'h0 && !prdata[4])
    else $error("reserved control bits not zero");
  one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("answer not after one wait state");
endmodule // ccr_regs_asserts

//--- verif/test_card_supply_regulator_control.sv
`timescale 1ns/10ps
// ----
// Self-checking bench for the converter registers
// ----
module test_card_supply_regulator_control;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, good = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, converter_enable, card_deactivate_req, ovf, step, irq;
  logic [1:0] vsel;
  logic [3:0] boost;
  logic [7:0] d;
  logic [32:0] exp_q[$];
  int miscompares = 0, tests_run = 0, pulses = 0;
  ccr_regs ccr_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .converter_output_good(good), .converter_enable(converter_enable),
    .card_deactivate_req(card_deactivate_req), .overflow_sensitivity_adjust(ovf),
    .step_up_inhibit(step), .converter_voltage_select(vsel), .regulator_current_boost(boost),
    .irq(irq));
  // 50 ns clock
  always #25 pclk = ~pclk;
  task check(string n, logic [32:0] s, logic [32:0] e);
    tests_run++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // One idle edge between transfers keeps each signal to one update per step
  task apb(logic w, logic [11:0] a, logic [31:0] v);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) miscompares++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(logic [11:0] a, logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task gap(int n);
    repeat (n) @(negedge pclk);
  endtask
  // Read answers against the oldest note; count deactivation pulses
  always @(posedge pclk) begin
    if (pready === 1'b1 && pwrite === 1'b0) check("read", {pslverr, prdata}, exp_q.pop_front());
    if (card_deactivate_req === 1'b1) pulses <= pulses + 1;
  end
  // Hang guard, far beyond the hundred-odd cycles needed
  initial begin
    #200000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    void'($urandom(24));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    gap(1);
    check("enable", converter_enable, 1'b1);
    check("boost", boost, 4'h0);
    rd(12'h000, 33'h0);
    rd(12'h004, 33'h0f);
    rd(12'h00c, 33'h0);
    rd(12'h014, {1'b1, 32'h0});
    // Every level code; bit 4 is always written as zero
    for (int i = 0; i < 4; i++) begin
      d = (8'($urandom) & 8'h0c) | 8'(i);
      apb(1'b1, 12'h000, {24'h0, d});
      rd(12'h000, {25'h0, d});
      gap(1);
      check("vsel", vsel, d[1:0]);
      check("ovf", ovf, d[3]);
      check("step", step, d[2]);
    end
    check("pulses", 33'(pulses), 33'h0);
    apb(1'b1, 12'h000, 32'h83);
    gap(2);
    check("enable", converter_enable, 1'b0);
    check("pulses", 33'(pulses), 33'h1);
    apb(1'b1, 12'h000, 32'h82);
    gap(2);
    check("pulses", 33'(pulses), 33'h1);
    d = 8'($urandom) | 8'h0f;
    apb(1'b1, 12'h004, {24'h0, d});
    rd(12'h004, {25'h0, d});
    gap(1);
    check("boost", boost, d[7:4]);
    apb(1'b1, 12'h00c, 32'h3);
    good <= 1'b1;
    gap(4);
    check("irq", irq, 1'b1);
    rd(12'h010, 33'h1);
    rd(12'h000, 33'he2);
    rd(12'h000, 33'ha2);
    rd(12'h008, 33'h1);
    rd(12'h010, 33'h1);
    apb(1'b1, 12'h008, 32'h1);
    apb(1'b1, 12'h00c, 32'h0);
    good <= 1'b0;
    gap(4);
    check("irq", irq, 1'b0);
    rd(12'h008, 33'h2);
    rd(12'h000, 33'h82);
    apb(1'b1, 12'h00c, 32'h2);
    gap(2);
    check("irq", irq, 1'b1);
    gap(2);
    report_and_stop;
  end
endmodule // test_card_supply_regulator_control
bind ccr_regs ccr_regs_asserts ccr_regs_asserts_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .converter_enable(converter_enable),
  .card_deactivate_req(card_deactivate_req),
  .overflow_sensitivity_adjust(overflow_sensitivity_adjust),
  .step_up_inhibit(step_up_inhibit), .converter_voltage_select(converter_voltage_select),
  .regulator_current_boost(regulator_current_boost));
